/* hw/remap_params.svh */
// Constants for the register redirection unit: register numbers, field positions, timing.
// Assumes a 125 MHz system clock; included by the package users by bare name.
`ifndef REMAP_PARAMS_SVH
`define REMAP_PARAMS_SVH

`define SLOT_FIRST 16'h1389
`define SLOT_LAST 16'h13BA
`define SLOT_COUNT 50
`define REG_FREQ_CMD 16'h0706
`define REG_CMD_WORD 16'h0707
`define REG_ALARM_RESET 16'h070F
`define REG_OUT_FREQ 16'h080A
`define REG_OP_STATUS 16'h080F
`define ALARM_RESET_VALUE 16'h0001
`define CMD_FWD_BIT 0
`define CMD_REV_BIT 1
`define CMD_GP_LO 2
`define CMD_GP_HI 10
`define STAT_FWD_BIT 0
`define STAT_REV_BIT 1
`define STAT_FAULT_BIT 11
`define STAT_SUPPLY_BIT 5
`define STAT_REMOTE_BIT 12
`define REBOOT_TIME_S 30
`define CLK_HZ 125000000
`define REBOOT_CYCLES (64'(`REBOOT_TIME_S) * 64'(`CLK_HZ))
`define EXC_ILLEGAL_ADDR 8'h02

`endif

/* hw/remap_pkg.sv */
// Types shared by the register redirection unit.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package remap_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACCESS = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b011,
    ST_REJECT = 3'b100
  } bridge_state_t;

  typedef enum logic [1:0] {
    DRIVE_STOPPED = 2'b00,
    DRIVE_FORWARD = 2'b01,
    DRIVE_REVERSE = 2'b10,
    DRIVE_FAULTED = 2'b11
  } drive_state_t;
endpackage
`default_nettype wire

/* hw/slot_table.sv */
// Fifty-entry redirection slot table, loaded only while boot loading is open.
// Assumes the loader presents one slot per cycle during boot.
`timescale 1ns/1ps
`default_nettype none
module slot_table #(
  parameter int SLOTS = 50
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Boot load
  input wire logic load_en,
  input wire logic [5:0] load_index,
  input wire logic [15:0] load_value,
  // Lookup
  input wire logic [5:0] read_index,
  output logic [15:0] read_value
);
  logic [15:0] slots [SLOTS];
  logic [15:0] next_slots [SLOTS];

  // Next table: writes only through the boot loader
  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      next_slots[i] = slots[i];
    end
    if (load_en && (int'(load_index) < SLOTS)) begin
      next_slots[load_index] = load_value;
    end
  end

  // Table storage, cleared to all-unused on reset
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < SLOTS; i++) begin
      slots[i] <= reset ? 16'h0000 : next_slots[i];
    end
  end

  // Combinational lookup
  always_comb begin
    read_value = (int'(read_index) < SLOTS) ? slots[read_index] : 16'h0000;
  end
endmodule // slot_table
`default_nettype wire

/* hw/modbus_register_remap.sv */
// Register redirection bridge between a Modbus/TCP request port and drive registers.
// Assumes the protocol engine delivers parsed requests and the drive port answers one word
// at a time with a done pulse; all inputs synchronous to sys_clk.
// How it works
// - Fifty slots occupy register numbers 5001 to 5050 for the network client.
// - Each slot holds a drive register number and client access goes to that register.
// - A slot holding zero drops writes and reads back zero.
// - Any non-slot register number passes straight to the drive, so both numbers reach it.
// - Multi-register reads and writes redirect each slot on its own in one transaction.
// - The table loads only at boot; a commit requests a device reset after thirty seconds.
// - A frequency setpoint is scaled and, if set while idle with no request, fault reset or keypad write pending, written to the frequency command register.
// - Nine input toggles drive bits 2 to 10 of the command word.
// - Forward sets bit 0 and clears bit 1, reverse the opposite, stop clears both.
// - A fault reset pressed while idle, with no request or keypad write pending, writes one to the alarm reset register whatever the command source.
// - Drive state is derived from operation status register bits.
// - Each status indicator follows its status word bit exactly.
// - Output frequency is taken from the drive_output_freq input, not read from the output frequency register.
`timescale 1ns/1ps
`default_nettype none
`include "remap_params.svh"
module modbus_register_remap #(
  parameter int SLOTS = `SLOT_COUNT,
  parameter longint REBOOT_CYCLES = `REBOOT_CYCLES,
  parameter logic [15:0] FREQ_SCALE = 16'h0064
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Boot load and commit
  input wire logic boot_load_en,
  input wire logic [5:0] boot_load_index,
  input wire logic [15:0] boot_load_value,
  input wire logic config_commit,
  output logic reboot_request,
  // Client request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_start,
  input wire logic [7:0] req_quantity,
  input wire logic [15:0] req_wdata,
  output logic req_wnext,
  output logic [15:0] rsp_rdata,
  output logic rsp_rvalid,
  output logic rsp_done,
  output logic rsp_exception,
  output logic [7:0] rsp_exc_code,
  output logic busy,
  // Drive register port
  output logic drv_req,
  output logic drv_write,
  output logic [15:0] drv_addr,
  output logic [15:0] drv_wdata,
  input wire logic drv_done,
  input wire logic [15:0] drv_rdata,
  // Keypad controls
  input wire logic kp_set_freq,
  input wire logic [15:0] kp_freq_value,
  input wire logic kp_forward,
  input wire logic kp_reverse,
  input wire logic kp_stop,
  input wire logic kp_fault_reset,
  input wire logic [8:0] kp_general_inputs,
  // Keypad indications
  input wire logic [15:0] drive_status_word,
  input wire logic [15:0] drive_output_freq,
  output logic [15:0] status_leds,
  output remap_pkg::drive_state_t drive_state,
  output logic [15:0] output_freq_display
);
  // Slot decode, used for the range check and per-word redirection
  function automatic logic is_slot(input logic [15:0] num);
    is_slot = (num >= `SLOT_FIRST) && (num <= `SLOT_LAST);
  endfunction

  remap_pkg::bridge_state_t state, next_state;
  logic [15:0] cur_num, next_cur_num;
  logic [7:0] left, next_left;
  logic wr, next_wr;
  logic [15:0] slot_val;
  logic [5:0] slot_idx;
  logic [15:0] next_rsp_rdata;
  logic next_rsp_rvalid, next_rsp_done, next_rsp_exception, next_req_wnext;
  logic [7:0] next_rsp_exc_code;
  logic next_drv_req, next_drv_write;
  logic [15:0] next_drv_addr, next_drv_wdata;
  logic [1:0] kp_pending, next_kp_pending; // 0 none, 1 freq, 2 cmd word, 3 alarm reset
  logic [15:0] cmd_word, next_cmd_word, freq_cmd, next_freq_cmd;
  logic [63:0] reboot_cnt, next_reboot_cnt;
  logic reboot_armed, next_reboot_armed, next_reboot_request;
  logic [16:0] range_end;

  assign slot_idx = 6'(cur_num - `SLOT_FIRST);
  assign range_end = 17'(req_start) + 17'(req_quantity) - 17'h00001;

  slot_table #(.SLOTS(SLOTS)) table_u (
    .sys_clk(sys_clk),
    .reset(reset),
    .load_en(boot_load_en),
    .load_index(boot_load_index),
    .load_value(boot_load_value),
    .read_index(slot_idx),
    .read_value(slot_val)
  );

  // Keypad command word and pending drive writes
  always_comb begin
    next_cmd_word = cmd_word;
    next_freq_cmd = freq_cmd;
    next_kp_pending = kp_pending;
    next_cmd_word[`CMD_GP_HI:`CMD_GP_LO] = kp_general_inputs;
    if (kp_forward) begin
      next_cmd_word[`CMD_FWD_BIT] = 1'b1;
      next_cmd_word[`CMD_REV_BIT] = 1'b0;
    end else if (kp_reverse) begin
      next_cmd_word[`CMD_FWD_BIT] = 1'b0;
      next_cmd_word[`CMD_REV_BIT] = 1'b1;
    end else if (kp_stop) begin
      next_cmd_word[`CMD_FWD_BIT] = 1'b0;
      next_cmd_word[`CMD_REV_BIT] = 1'b0;
    end
    if (kp_set_freq) begin
      next_freq_cmd = 16'(kp_freq_value * FREQ_SCALE);
    end
    if (state == remap_pkg::ST_IDLE && !req_valid && kp_pending == 2'h0) begin
      if (kp_fault_reset) next_kp_pending = 2'd3;
      else if (kp_set_freq) next_kp_pending = 2'd1;
      else if (next_cmd_word != cmd_word) next_kp_pending = 2'd2;
    end else if (state == remap_pkg::ST_WAIT && drv_done && kp_pending != 2'h0 &&
                 left == 8'h00) begin
      next_kp_pending = 2'd0;
    end
  end

  // Bridge sequencer: one drive access per word, none for a zero slot, ascending
  always_comb begin
    next_state = state;
    next_cur_num = cur_num;
    next_left = left;
    next_wr = wr;
    next_rsp_rdata = rsp_rdata;
    next_rsp_rvalid = 1'b0;
    next_rsp_done = 1'b0;
    next_rsp_exception = 1'b0;
    next_rsp_exc_code = rsp_exc_code;
    next_req_wnext = 1'b0;
    next_drv_req = 1'b0;
    next_drv_write = drv_write;
    next_drv_addr = drv_addr;
    next_drv_wdata = drv_wdata;
    case (state)
      remap_pkg::ST_IDLE: begin
        if (req_valid) begin
          next_cur_num = req_start;
          next_left = req_quantity;
          next_wr = req_write;
          if (req_quantity == 8'h00 ||
              (is_slot(req_start) && range_end > 17'(`SLOT_LAST))) begin
            next_state = remap_pkg::ST_REJECT;
          end else begin
            next_state = remap_pkg::ST_ACCESS;
          end
        end else if (kp_pending != 2'd0) begin
          next_left = 8'h00;
          next_drv_req = 1'b1;
          next_drv_write = 1'b1;
          next_drv_addr = (kp_pending == 2'd3) ? `REG_ALARM_RESET :
                          (kp_pending == 2'd1) ? `REG_FREQ_CMD : `REG_CMD_WORD;
          next_drv_wdata = (kp_pending == 2'd3) ? `ALARM_RESET_VALUE :
                           (kp_pending == 2'd1) ? freq_cmd : cmd_word;
          next_state = remap_pkg::ST_WAIT;
        end
      end
      remap_pkg::ST_ACCESS: begin
        if (is_slot(cur_num) && slot_val == 16'h0000) begin
          next_rsp_rdata = 16'h0000;
          next_rsp_rvalid = !wr;
          next_req_wnext = wr;
          next_left = left - 8'h01;
          next_cur_num = cur_num + 16'h0001;
          next_state = (left == 8'h01) ? remap_pkg::ST_DONE : remap_pkg::ST_ACCESS;
        end else begin
          next_drv_req = 1'b1;
          next_drv_write = wr;
          next_drv_addr = is_slot(cur_num) ? slot_val : cur_num;
          next_drv_wdata = req_wdata;
          next_state = remap_pkg::ST_WAIT;
        end
      end
      remap_pkg::ST_WAIT: begin
        if (drv_done) begin
          if (left == 8'h00) begin
            next_state = remap_pkg::ST_IDLE;
          end else begin
            next_rsp_rdata = drv_rdata;
            next_rsp_rvalid = !wr;
            next_req_wnext = wr;
            next_left = left - 8'h01;
            next_cur_num = cur_num + 16'h0001;
            next_state = (left == 8'h01) ? remap_pkg::ST_DONE : remap_pkg::ST_ACCESS;
          end
        end
      end
      remap_pkg::ST_DONE: begin
        next_rsp_done = 1'b1;
        next_state = remap_pkg::ST_IDLE;
      end
      remap_pkg::ST_REJECT: begin
        next_rsp_done = 1'b1;
        next_rsp_exception = 1'b1;
        next_rsp_exc_code = `EXC_ILLEGAL_ADDR;
        next_state = remap_pkg::ST_IDLE;
      end
      default: next_state = remap_pkg::ST_IDLE;
    endcase
  end

  // Commit: hold reset request off for the reboot time, then pulse it
  always_comb begin
    next_reboot_armed = reboot_armed;
    next_reboot_cnt = reboot_cnt;
    next_reboot_request = 1'b0;
    if (config_commit && !reboot_armed) begin
      next_reboot_armed = 1'b1;
      next_reboot_cnt = 64'h0;
    end else if (reboot_armed) begin
      if (reboot_cnt >= 64'(REBOOT_CYCLES) - 64'h1) begin
        next_reboot_request = 1'b1;
        next_reboot_armed = 1'b0;
      end else begin
        next_reboot_cnt = reboot_cnt + 64'h1;
      end
    end
  end

  // Register all state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= remap_pkg::ST_IDLE;
      cur_num <= 16'h0000;
      left <= 8'h00;
      wr <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_rvalid <= 1'b0;
      rsp_done <= 1'b0;
      rsp_exception <= 1'b0;
      rsp_exc_code <= 8'h00;
      req_wnext <= 1'b0;
      drv_req <= 1'b0;
      drv_write <= 1'b0;
      drv_addr <= 16'h0000;
      drv_wdata <= 16'h0000;
      kp_pending <= 2'd0;
      cmd_word <= 16'h0000;
      freq_cmd <= 16'h0000;
      reboot_cnt <= 64'h0;
      reboot_armed <= 1'b0;
      reboot_request <= 1'b0;
      busy <= 1'b0;
      status_leds <= 16'h0000;
      drive_state <= remap_pkg::DRIVE_STOPPED;
      output_freq_display <= 16'h0000;
    end else begin
      state <= next_state;
      cur_num <= next_cur_num;
      left <= next_left;
      wr <= next_wr;
      rsp_rdata <= next_rsp_rdata;
      rsp_rvalid <= next_rsp_rvalid;
      rsp_done <= next_rsp_done;
      rsp_exception <= next_rsp_exception;
      rsp_exc_code <= next_rsp_exc_code;
      req_wnext <= next_req_wnext;
      drv_req <= next_drv_req;
      drv_write <= next_drv_write;
      drv_addr <= next_drv_addr;
      drv_wdata <= next_drv_wdata;
      kp_pending <= next_kp_pending;
      cmd_word <= next_cmd_word;
      freq_cmd <= next_freq_cmd;
      reboot_cnt <= next_reboot_cnt;
      reboot_armed <= next_reboot_armed;
      reboot_request <= next_reboot_request;
      busy <= (next_state != remap_pkg::ST_IDLE);
      status_leds <= drive_status_word;
      output_freq_display <= drive_output_freq;
      if (drive_status_word[`STAT_FAULT_BIT]) drive_state <= remap_pkg::DRIVE_FAULTED;
      else if (drive_status_word[`STAT_FWD_BIT]) drive_state <= remap_pkg::DRIVE_FORWARD;
      else if (drive_status_word[`STAT_REV_BIT]) drive_state <= remap_pkg::DRIVE_REVERSE;
      else drive_state <= remap_pkg::DRIVE_STOPPED;
    end
  end
endmodule // modbus_register_remap
`default_nettype wire

/* test/drive_model.sv */
// Drive register space behind the bridge, answering after a selectable lag.
// Assumes one outstanding request and a shared sys_clk.
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  // Clock and lag
  input wire logic sys_clk,
  input wire logic [3:0] lag,
  // Drive register port
  input wire logic drv_req,
  input wire logic drv_write,
  input wire logic [15:0] drv_addr,
  input wire logic [15:0] drv_wdata,
  output logic drv_done,
  output logic [15:0] drv_rdata
);
  logic [15:0] mem [0:4095];
  logic [15:0] last;
  // Serve each request, then scramble the read bus
  initial begin
    drv_done = 1'b0;
    drv_rdata = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
    forever begin
      @(posedge sys_clk);
      if (drv_req) begin
        repeat (lag) @(posedge sys_clk);
        // Alarm reset is dropped while a run bit is set
        if (drv_write && !(drv_addr == 16'h070F && mem[12'h707][1:0] != 2'b00))
          mem[drv_addr[11:0]] = drv_wdata;
        last = mem[drv_addr[11:0]];
        drv_done <= 1'b1;
        drv_rdata <= last;
        @(posedge sys_clk);
        drv_done <= 1'b0;
        drv_rdata <= ~last;
      end
    end
  end
endmodule // drive_model
`default_nettype wire

/* test/modbus_register_remap_assertions.sv */
// Timing checks on replies, rejects, keypad writes and indications.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module modbus_register_remap_checker #(
  parameter longint REBOOT_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk, reset,
  // Client and commit
  input wire logic req_valid, busy, rsp_done, rsp_exception, rsp_rvalid,
  input wire logic config_commit, reboot_request,
  input wire logic [15:0] req_start, rsp_rdata,
  input wire logic [7:0] req_quantity, rsp_exc_code,
  // Drive port and keypad
  input wire logic drv_req, drv_write, drv_done, kp_fault_reset,
  input wire logic [15:0] drv_addr, drv_wdata, drv_rdata,
  // Indications
  input wire logic [15:0] drive_status_word, drive_output_freq,
  input wire logic [15:0] status_leds, output_freq_display,
  input wire remap_pkg::drive_state_t drive_state
);
  longint elapsed;
  // Cycles since the last commit
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      elapsed <= 0;
    end else if (config_commit) begin
      elapsed <= 1;
    end else if (elapsed != 0) begin
      elapsed <= elapsed + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_leds_follow: assert property (
    !$past(reset) |-> status_leds == $past(drive_status_word))
    else $error("status lights differ from status word");
  a_fault_state: assert property (
    !$past(reset) && $past(drive_status_word[11]) |-> drive_state == remap_pkg::DRIVE_FAULTED)
    else $error("fault bit not shown as faulted");
  a_freq_shown: assert property (
    !$past(reset) |-> output_freq_display == $past(drive_output_freq))
    else $error("output frequency not shown");
  a_range_reject: assert property (
    req_valid && !busy && req_start >= 16'h1389 && req_start <= 16'h13BA &&
    (req_quantity == 8'h00 || 17'(req_start) + 17'(req_quantity) > 17'h13BB)
    |-> ##2 rsp_done && rsp_exception && rsp_exc_code == 8'h02)
    else $error("bad slot range not rejected");
  a_exc_with_done: assert property (
    rsp_exception |-> rsp_done)
    else $error("exception without done");
  a_read_reply: assert property (
    drv_done && !drv_write |=> rsp_rvalid && rsp_rdata == $past(drv_rdata))
    else $error("drive read not returned");
  a_fault_reset: assert property (
    kp_fault_reset && !busy && !req_valid
    |-> ##[1:40] drv_req && drv_addr == 16'h070F && drv_wdata == 16'h0001)
    else $error("alarm reset write missing");
  a_reboot_time: assert property (
    reboot_request |-> elapsed == REBOOT_CYCLES || elapsed == REBOOT_CYCLES + 1)
    else $error("reboot request at wrong time");
  c_reject: cover property (rsp_exception);
  c_read_word: cover property (rsp_rvalid);
  c_reboot: cover property (reboot_request);
endmodule // modbus_register_remap_checker
bind modbus_register_remap modbus_register_remap_checker #(
  .REBOOT_CYCLES(REBOOT_CYCLES)
) checker_inst (.*);
`default_nettype wire

/* test/modbus_register_remap_tb.sv */
// Bench: client transfers, keypad actions, indications and commit.
// Assumes the drive model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module modbus_register_remap_tb;
  logic sys_clk = 1'b0;
  logic reset, boot_load_en, config_commit, reboot_request, req_valid, req_write;
  logic req_wnext, rsp_rvalid, rsp_done, rsp_exception, busy, drv_req, drv_write, drv_done;
  logic kp_set_freq, kp_forward, kp_reverse, kp_stop, kp_fault_reset, exc;
  logic [3:0] lag;
  logic [5:0] boot_load_index;
  logic [7:0] req_quantity, rsp_exc_code;
  logic [8:0] kp_general_inputs;
  logic [15:0] boot_load_value, req_start, req_wdata, rsp_rdata, drv_addr, drv_wdata;
  logic [15:0] drv_rdata, kp_freq_value, drive_status_word, drive_output_freq;
  logic [15:0] status_leds, output_freq_display;
  logic [15:0] wq [8];
  logic [15:0] rq [8];
  remap_pkg::drive_state_t drive_state;
  int err_count, num_checks;
  modbus_register_remap #(.REBOOT_CYCLES(20)) modbus_register_remap_inst (.*);
  drive_model drive_model_inst (.*);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic nap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One client transfer; words read land in rq, words written come from wq
  task automatic xfer(input logic wr, input logic [15:0] st, input logic [7:0] qty);
    int n;
    int t;
    n = 0;
    t = 0;
    while (busy) nap(1);
    {req_valid, req_write, req_start, req_quantity, req_wdata} = {1'b1, wr, st, qty, wq[0]};
    nap(1);
    req_valid = 1'b0;
    do begin
      nap(1);
      t++;
      if (rsp_rvalid) rq[n] = rsp_rdata;
      if (rsp_rvalid || req_wnext) n++;
      req_wdata = wq[n];
    end while (!rsp_done && t < 300);
    exc = rsp_exception;
    if (t >= 300) begin
      err_count++;
      $display("MISMATCH %0t transfer timed out", $time);
    end
  endtask
  // Pulse one keypad button, then look at the drive register it reaches
  task automatic kp(input logic [4:0] p, input logic [11:0] a, input logic [15:0] e);
    {kp_set_freq, kp_forward, kp_reverse, kp_stop, kp_fault_reset} = p;
    nap(1);
    {kp_set_freq, kp_forward, kp_reverse, kp_stop, kp_fault_reset} = 5'h00;
    nap(30);
    `CHK(drive_model_inst.mem[a], e)
  endtask
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    static logic [15:0] map [5] = '{16'h0706, 16'h0707, 16'h080A, 16'h0816, 16'h080F};
    static logic [15:0] st [4] = '{16'h1021, 16'h0802, 16'h0002, 16'h0000};
    static logic [1:0] ds [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    int k;
    {reset, boot_load_en, config_commit, req_valid, req_write, lag} = 9'h100;
    {kp_set_freq, kp_forward, kp_reverse, kp_stop, kp_fault_reset} = 5'h00;
    {boot_load_index, boot_load_value, req_start, req_quantity, req_wdata} = '0;
    {kp_freq_value, kp_general_inputs, drive_status_word, drive_output_freq} = '0;
    nap(6);
    reset = 1'b0;
    for (int i = 0; i < 50; i++) begin
      {boot_load_en, boot_load_index} = {1'b1, 6'(i)};
      boot_load_value = (i < 5) ? map[i] : (i == 49) ? 16'h0100 : 16'h0000;
      nap(1);
    end
    boot_load_en = 1'b0;
    wq[0] = 16'h1234;
    wq[1] = 16'h0003;
    xfer(1'b1, 16'h1389, 8'h02);
    `CHK(drive_model_inst.mem[12'h706], 16'h1234)
    `CHK(drive_model_inst.mem[12'h707], 16'h0003)
    xfer(1'b0, 16'h1389, 8'h02);
    `CHK({rq[0], rq[1]}, {16'h1234, 16'h0003})
    xfer(1'b0, 16'h0706, 8'h01);
    `CHK(rq[0], 16'h1234)
    lag = 4'h3;
    drive_model_inst.mem[12'h80A] = 16'h0933;
    drive_model_inst.mem[12'h816] = 16'h0155;
    drive_model_inst.mem[12'h80F] = 16'h0021;
    drive_model_inst.mem[12'h100] = 16'h00AA;
    xfer(1'b0, 16'h138B, 8'h03);
    `CHK({rq[0], rq[1], rq[2]}, {16'h0933, 16'h0155, 16'h0021})
    wq[0] = 16'hBEEF;
    xfer(1'b1, 16'h1392, 8'h01);
    xfer(1'b0, 16'h1392, 8'h01);
    `CHK({rq[0], drive_model_inst.mem[0]}, 32'h0)
    xfer(1'b0, 16'h13BA, 8'h01);
    `CHK({exc, rq[0]}, {1'b0, 16'h00AA})
    xfer(1'b0, 16'h13BA, 8'h02);
    `CHK(exc, 1'b1)
    xfer(1'b1, 16'h1389, 8'h00);
    `CHK({exc, rsp_exc_code}, {1'b1, 8'h02})
    lag = 4'h1;
    kp_general_inputs = 9'h181;
    kp_freq_value = 16'h0010;
    kp(5'b01000, 12'h707, 16'h0605);
    kp(5'b00100, 12'h707, 16'h0606);
    kp(5'b00010, 12'h707, 16'h0604);
    kp(5'b00001, 12'h70F, 16'h0001);
    kp(5'b10000, 12'h706, 16'h0640);
    drive_output_freq = 16'h0933;
    foreach (st[i]) begin
      drive_status_word = st[i];
      nap(2);
      `CHK({status_leds, drive_state}, {st[i], ds[i]})
    end
    `CHK(output_freq_display, 16'h0933)
    config_commit = 1'b1;
    nap(1);
    config_commit = 1'b0;
    k = 1;
    while (!reboot_request && k < 40) begin
      nap(1);
      k++;
    end
    `CHK(k inside {20, 21}, 1'b1)
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
endmodule // modbus_register_remap_tb
`default_nettype wire
